/* File: bench/cesf_regs_checker.sv */
// Port checker for the error-save and feature register bank.
// Bound to cesf_regs; sees only its ports, core clock domain.
`timescale 1ns/100ps
module cesf_regs_checker
    import cesf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire cesf_req_s req_i,
    input wire logic mc_error_i,
    input wire cesf_arch_state_s arch_state_i,
    input wire logic ds_fault_i,
    input wire logic [63:0] thermal_event_i,
    input wire logic [63:0] rdata_o,
    input wire logic ack_o,
    input wire logic shutdown_o,
    input wire logic [63:0] clock_mod_ctrl_o,
    input wire logic [63:0] thermal_irq_ctrl_o,
    input wire logic fast_string_en_o,
    input wire logic fopcode_compat_en_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    wire logic [11:0] a = req_i.addr;
    wire logic wr = req_i.wr;
    wire logic sv = a >= ADDR_SAVE_GPR_D && a <= ADDR_SAVE_INSTR_PTR;
    // ==========================================================
    // Assertions
    a_ack_follows: assert property ((req_i.rd || wr) |=> ack_o)
        else $error("no ack after request");
    a_ds_to_shut: assert property (ds_fault_i |=> shutdown_o)
        else $error("shutdown missed fault");
    a_shut_holds: assert property (
        shutdown_o && !(wr && a == ADDR_ERR_MISC_STATUS) |=> shutdown_o)
        else $error("fault flag dropped");
    a_fast_wr: assert property (wr && a == ADDR_FEATURE_ENABLE
        |=> fast_string_en_o == $past(req_i.wdata[0]))
        else $error("fast string bit wrong");
    a_fop_wr: assert property (wr && a == ADDR_FEATURE_ENABLE
        |=> fopcode_compat_en_o == $past(req_i.wdata[2]))
        else $error("opcode compat bit wrong");
    a_clkmod_wr: assert property (wr && a == ADDR_CLOCK_MOD_CONTROL
        |=> clock_mod_ctrl_o == $past(req_i.wdata))
        else $error("clock modulation copy wrong");
    a_save_hi: assert property (req_i.rd && sv
        |=> rdata_o[63:32] == 32'h0)
        else $error("save upper half not zero");
    a_save_clear: assert property (
        wr && sv && !mc_error_i ##2 req_i.rd && a == $past(a, 2)
        && !$past(mc_error_i) && !mc_error_i |=> rdata_o == 64'h0)
        else $error("save not cleared");
    c_error: cover property (mc_error_i);
    c_fault: cover property (ds_fault_i ##1 shutdown_o);
    c_feat: cover property (req_i.rd && a == ADDR_FEATURE_ENABLE);
endmodule
bind cesf_regs cesf_regs_checker chk (.*);

/* File: bench/testbench.sv */
// Self-checking bench for the error-save and feature register bank.
// Drives cesf_regs directly; inputs change on the falling edge.
`timescale 1ns/100ps
module testbench;
    import cesf_pkg::*;
    logic core_clk_i = 0;
    logic reset_n_i = 0;
    cesf_req_s req_i = '0;
    logic mc_error_i = 0;
    cesf_arch_state_s arch_state_i = '0;
    logic ds_fault_i = 0;
    logic [63:0] thermal_event_i = '0;
    logic [63:0] rdata_o, clock_mod_ctrl_o, thermal_irq_ctrl_o, rd;
    logic ack_o, shutdown_o, fast_string_en_o, fopcode_compat_en_o;
    int bad_count = 0;
    int checks = 0;
    int cycles = 0;
    cesf_regs uut (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .req_i(req_i), .mc_error_i(mc_error_i), .arch_state_i(arch_state_i),
        .ds_fault_i(ds_fault_i), .thermal_event_i(thermal_event_i),
        .rdata_o(rdata_o), .ack_o(ack_o), .shutdown_o(shutdown_o),
        .clock_mod_ctrl_o(clock_mod_ctrl_o),
        .thermal_irq_ctrl_o(thermal_irq_ctrl_o),
        .fast_string_en_o(fast_string_en_o),
        .fopcode_compat_en_o(fopcode_compat_en_o));
    always #5 core_clk_i = ~core_clk_i;
    // Whole run is well under a thousand cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            close_out();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // One access; request held for one cycle, ack checked, then released
    task automatic acc(input logic w, input logic [11:0] ad,
                       input logic [63:0] d);
        @(negedge core_clk_i);
        req_i = '{rd: !w, wr: w, addr: ad, wdata: d};
        @(negedge core_clk_i);
        chk({63'h0, ack_o}, 64'h1);
        rd = rdata_o;
        req_i = '0;
    endtask
    task automatic rchk(input logic [11:0] ad, input logic [63:0] exp);
        acc(1'b0, ad, 64'h0);
        chk(rd, exp);
    endtask
    task automatic close_out();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        for (int i = 0; i < 8; i++)
            rchk(ADDR_SAVE_GPR_D + 12'(i), 64'h0);
        rchk(ADDR_FEATURE_ENABLE, 64'h1);
        $display("reset test done");
    endtask
    task automatic t_capture();
        @(negedge core_clk_i);
        for (int i = 0; i < 7; i++)
            arch_state_i[(6-i)*32 +: 32] = 32'hC0DE0000 + 32'(i);
        mc_error_i = 1;
        @(negedge core_clk_i);
        mc_error_i = 0;
        // New state without an error must not leak in
        arch_state_i = '1;
        for (int i = 0; i < 7; i++)
            rchk(ADDR_SAVE_GPR_D + 12'(i), 64'hC0DE0000 + 64'(i));
        acc(1'b1, ADDR_SAVE_DST_INDEX, '1);
        rchk(ADDR_SAVE_DST_INDEX, 64'h0);
        rchk(ADDR_SAVE_FRAME_PTR, 64'hC0DE0003);
        $display("capture test done");
    endtask
    task automatic t_fault();
        @(negedge core_clk_i);
        ds_fault_i = 1;
        @(negedge core_clk_i);
        ds_fault_i = 0;
        chk({63'h0, shutdown_o}, 64'h1);
        repeat (5) @(negedge core_clk_i);
        rchk(ADDR_ERR_MISC_STATUS, 64'h1);
        acc(1'b1, ADDR_ERR_MISC_STATUS, 64'h0);
        rchk(ADDR_ERR_MISC_STATUS, 64'h0);
        chk({63'h0, shutdown_o}, 64'h0);
        $display("fault test done");
    endtask
    // Same-cycle races: capture and set must beat a software clear
    task automatic t_race();
        @(negedge core_clk_i);
        arch_state_i = '0;
        arch_state_i.gpr_d = 32'h0000_5A5A;
        mc_error_i = 1;
        req_i = '{rd: 1'b0, wr: 1'b1, addr: ADDR_SAVE_GPR_D, wdata: 64'h0};
        @(negedge core_clk_i);
        mc_error_i = 0;
        ds_fault_i = 1;
        req_i = '{rd: 1'b0, wr: 1'b1, addr: ADDR_ERR_MISC_STATUS,
                  wdata: 64'h0};
        @(negedge core_clk_i);
        ds_fault_i = 0;
        req_i = '0;
        rchk(ADDR_SAVE_GPR_D, 64'h5A5A);
        rchk(ADDR_ERR_MISC_STATUS, 64'h1);
        acc(1'b1, ADDR_ERR_MISC_STATUS, 64'h0);
        chk({63'h0, shutdown_o}, 64'h0);
        $display("race test done");
    endtask
    task automatic t_thermal();
        acc(1'b1, ADDR_CLOCK_MOD_CONTROL, 64'hA5A50000_00005A5A);
        chk(clock_mod_ctrl_o, 64'hA5A50000_00005A5A);
        rchk(ADDR_CLOCK_MOD_CONTROL, 64'hA5A50000_00005A5A);
        acc(1'b1, ADDR_THERMAL_IRQ_CONTROL, 64'h3);
        chk(thermal_irq_ctrl_o, 64'h3);
        rchk(ADDR_THERMAL_IRQ_CONTROL, 64'h3);
        acc(1'b1, ADDR_THERMAL_STATE, 64'hF0);
        thermal_event_i = 64'h1;
        @(negedge core_clk_i);
        thermal_event_i = '0;
        rchk(ADDR_THERMAL_STATE, 64'hF1);
        $display("thermal test done");
    endtask
    task automatic t_feature();
        acc(1'b1, ADDR_FEATURE_ENABLE, '1);
        rchk(ADDR_FEATURE_ENABLE, 64'h5);
        acc(1'b1, ADDR_FEATURE_ENABLE, 64'h4);
        chk({62'h0, fast_string_en_o, fopcode_compat_en_o}, 64'h1);
        rchk(12'h1FF, 64'h0);
        $display("feature test done");
    endtask
    initial begin
        repeat (4) @(negedge core_clk_i);
        reset_n_i = 1;
        t_reset();
        t_capture();
        t_fault();
        t_race();
        t_thermal();
        t_feature();
        close_out();
    end
endmodule

/* File: src/cesf_pkg.sv */
// Package for the error-save and feature register bank.
// Assumes a 64-bit model-specific register access port in the core clock.
package cesf_pkg;

    // ==========================================================
    // Register indices
    localparam logic [11:0] ADDR_SAVE_GPR_D = 12'h183;
    localparam logic [11:0] ADDR_SAVE_SRC_INDEX = 12'h184;
    localparam logic [11:0] ADDR_SAVE_DST_INDEX = 12'h185;
    localparam logic [11:0] ADDR_SAVE_FRAME_PTR = 12'h186;
    localparam logic [11:0] ADDR_SAVE_STACK_PTR = 12'h187;
    localparam logic [11:0] ADDR_SAVE_FLAGS = 12'h188;
    localparam logic [11:0] ADDR_SAVE_INSTR_PTR = 12'h189;
    localparam logic [11:0] ADDR_ERR_MISC_STATUS = 12'h18A;
    localparam logic [11:0] ADDR_CLOCK_MOD_CONTROL = 12'h19A;
    localparam logic [11:0] ADDR_THERMAL_IRQ_CONTROL = 12'h19B;
    localparam logic [11:0] ADDR_THERMAL_STATE = 12'h19C;
    localparam logic [11:0] ADDR_FEATURE_ENABLE = 12'h1A0;

    // ==========================================================
    // Field layout
    localparam int SAVE_COUNT = 7;
    localparam int SAVE_WIDTH = 32;
    localparam int DS_FAULT_BIT = 0;
    localparam int FAST_STRING_BIT = 0;
    localparam int FOPCODE_COMPAT_BIT = 2;
    localparam logic [63:0] FEATURE_WR_MASK = 64'h0000_0000_0000_0005;

    // ==========================================================
    // Reset values
    localparam logic [SAVE_WIDTH-1:0] SAVE_RESET = 32'h0000_0000;
    localparam logic [63:0] CLOCK_MOD_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] THERMAL_IRQ_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] THERMAL_STATE_RESET = 64'h0000_0000_0000_0000;
    localparam logic [63:0] FEATURE_RESET = 64'h0000_0000_0000_0001;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [31:0] gpr_d;
        logic [31:0] src_index;
        logic [31:0] dst_index;
        logic [31:0] frame_ptr;
        logic [31:0] stack_ptr;
        logic [31:0] flags;
        logic [31:0] instr_ptr;
    } cesf_arch_state_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [63:0] wdata;
    } cesf_req_s;

    // Decode an index into a save slot; returns SAVE_COUNT if none.
    function automatic logic [2:0] cesf_save_slot(input logic [11:0] a);
        logic [11:0] d;
        d = a - ADDR_SAVE_GPR_D;
        if (a >= ADDR_SAVE_GPR_D && a <= ADDR_SAVE_INSTR_PTR) begin
            return d[2:0];
        end
        return 3'(SAVE_COUNT);
    endfunction

endpackage

/* File: src/cesf_regs.sv */
// Error-save, thermal control and feature-enable register bank.
// Assumes one register access per cycle from the core's register port,
// and architectural state presented alongside a one-cycle error pulse.
`timescale 1ns/100ps
module cesf_regs
    import cesf_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire cesf_req_s req_i,
    input wire logic mc_error_i,
    input wire cesf_arch_state_s arch_state_i,
    input wire logic ds_fault_i,
    input wire logic [63:0] thermal_event_i,
    output logic [63:0] rdata_o,
    output logic ack_o,
    output logic shutdown_o,
    output logic [63:0] clock_mod_ctrl_o,
    output logic [63:0] thermal_irq_ctrl_o,
    output logic fast_string_en_o,
    output logic fopcode_compat_en_o
);

    // ==========================================================
    // State
    logic [SAVE_WIDTH-1:0] save_q [SAVE_COUNT];
    logic [SAVE_WIDTH-1:0] next_save [SAVE_COUNT];
    logic ds_fault_q;
    logic next_ds_fault;
    logic [63:0] clock_mod_q;
    logic [63:0] next_clock_mod;
    logic [63:0] thermal_irq_q;
    logic [63:0] next_thermal_irq;
    logic [63:0] thermal_state_q;
    logic [63:0] next_thermal_state;
    logic [63:0] feature_q;
    logic [63:0] next_feature;
    logic [63:0] rdata_q;
    logic [63:0] next_rdata;
    logic ack_q;
    logic [SAVE_WIDTH-1:0] arch_vec [SAVE_COUNT];
    logic [2:0] wr_slot;
    logic [2:0] rd_slot;

    // ==========================================================
    // Architectural sources in address order
    always_comb begin
        arch_vec[0] = arch_state_i.gpr_d;
        arch_vec[1] = arch_state_i.src_index;
        arch_vec[2] = arch_state_i.dst_index;
        arch_vec[3] = arch_state_i.frame_ptr;
        arch_vec[4] = arch_state_i.stack_ptr;
        arch_vec[5] = arch_state_i.flags;
        arch_vec[6] = arch_state_i.instr_ptr;
    end

    assign wr_slot = cesf_save_slot(req_i.addr);
    assign rd_slot = wr_slot;

    // ==========================================================
    // Save registers
    always_comb begin
        for (int i = 0; i < SAVE_COUNT; i++) begin
            next_save[i] = save_q[i];
            // Write data is ignored: any write clears the slot
            if (req_i.wr && wr_slot == 3'(i)) begin
                next_save[i] = SAVE_RESET;
            end
            // Error capture wins over a same-cycle clear
            if (mc_error_i) begin
                next_save[i] = arch_vec[i];
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < SAVE_COUNT; i++) begin
                save_q[i] <= SAVE_RESET;
            end
        end else begin
            save_q <= next_save;
        end
    end

    // ==========================================================
    // Control and status registers
    always_comb begin
        next_ds_fault = ds_fault_q;
        next_clock_mod = clock_mod_q;
        next_thermal_irq = thermal_irq_q;
        next_thermal_state = thermal_state_q | thermal_event_i;
        next_feature = feature_q;
        if (req_i.wr) begin
            case (req_i.addr)
                ADDR_ERR_MISC_STATUS: begin
                    next_ds_fault = req_i.wdata[DS_FAULT_BIT];
                end
                ADDR_CLOCK_MOD_CONTROL: begin
                    next_clock_mod = req_i.wdata;
                end
                ADDR_THERMAL_IRQ_CONTROL: begin
                    next_thermal_irq = req_i.wdata;
                end
                ADDR_THERMAL_STATE: begin
                    // New events still land over a software write
                    next_thermal_state = req_i.wdata | thermal_event_i;
                end
                ADDR_FEATURE_ENABLE: begin
                    next_feature = req_i.wdata & FEATURE_WR_MASK;
                end
                default: begin
                end
            endcase
        end
        // Set beats a same-cycle clear
        if (ds_fault_i) begin
            next_ds_fault = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ds_fault_q <= 1'b0;
            clock_mod_q <= CLOCK_MOD_RESET;
            thermal_irq_q <= THERMAL_IRQ_RESET;
            thermal_state_q <= THERMAL_STATE_RESET;
            feature_q <= FEATURE_RESET;
        end else begin
            ds_fault_q <= next_ds_fault;
            clock_mod_q <= next_clock_mod;
            thermal_irq_q <= next_thermal_irq;
            thermal_state_q <= next_thermal_state;
            feature_q <= next_feature;
        end
    end

    // ==========================================================
    // Read path, one cycle after the request
    always_comb begin
        next_rdata = 64'h0000_0000_0000_0000;
        if (req_i.rd) begin
            if (rd_slot != 3'(SAVE_COUNT)) begin
                next_rdata = {32'h0000_0000, save_q[rd_slot]};
            end else begin
                case (req_i.addr)
                    ADDR_ERR_MISC_STATUS: begin
                        next_rdata = {63'h0, ds_fault_q};
                    end
                    ADDR_CLOCK_MOD_CONTROL: begin
                        next_rdata = clock_mod_q;
                    end
                    ADDR_THERMAL_IRQ_CONTROL: begin
                        next_rdata = thermal_irq_q;
                    end
                    ADDR_THERMAL_STATE: begin
                        next_rdata = thermal_state_q;
                    end
                    ADDR_FEATURE_ENABLE: begin
                        next_rdata = feature_q;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 64'h0000_0000_0000_0000;
            ack_q <= 1'b0;
        end else begin
            rdata_q <= next_rdata;
            ack_q <= req_i.rd | req_i.wr;
        end
    end

    // ==========================================================
    // Outputs
    assign rdata_o = rdata_q;
    assign ack_o = ack_q;
    assign shutdown_o = ds_fault_q;
    assign clock_mod_ctrl_o = clock_mod_q;
    assign thermal_irq_ctrl_o = thermal_irq_q;
    assign fast_string_en_o = feature_q[FAST_STRING_BIT];
    assign fopcode_compat_en_o = feature_q[FOPCODE_COMPAT_BIT];

endmodule
